// ===== hdl/adc_ctrl_pkg.sv
// Shared constants for the single-conversion converter controller
package adc_ctrl_pkg;
    // Transfer kinds on the I/O port (op none is the bare start form)
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_CHAN_WR = 3'h1;
    localparam logic [2:0] OP_CHAN_RD = 3'h2;
    localparam logic [2:0] OP_GAIN_WR = 3'h3;
    localparam logic [2:0] OP_RESULT_RD = 3'h4;
    // Function field attached to a transfer
    localparam logic [1:0] FN_NONE = 2'h0;
    localparam logic [1:0] FN_START = 2'h1;
    localparam logic [1:0] FN_CLEAR = 2'h2;
    localparam logic [1:0] FN_PULSE = 2'h3;
    // Accumulator layout, vector bit 15 is accumulator bit 0 (MSB)
    localparam int ACC_W = 16;
    localparam int ACC_CHAN_LSB = 0;
    localparam int CHAN_W = 8;
    localparam int ACC_GAIN_LSB = 14;
    localparam int GAIN_W = 2;
    localparam int MUX_SEL_W = 5;
    localparam int CONV_W = 12;
    localparam int FACTOR_W = 4;
    // Reset values of the registers
    localparam logic [7:0] CHAN_RST = 8'h00;
    localparam logic [1:0] GAIN_RST = 2'h0;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    // Sampling clock timing
    localparam int CLK_MHZ = 100;
    localparam int SAMPLE_PERIOD_US = 10;
    localparam int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_US * CLK_MHZ;
endpackage

// ===== hdl/sample_clock_div.sv
// Internal sampling clock: one-cycle tick every PERIOD_CYC cycles
`timescale 1ns/100ps
module sample_clock_div #(
    parameter int PERIOD_CYC = adc_ctrl_pkg::SAMPLE_PERIOD_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Control and tick
    input wire logic enable_i,
    output logic tick_o
);
    localparam int CW = $clog2(PERIOD_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_tick;

    // Free-running count while enabled, held at zero otherwise
    always_comb begin
        next_count = '0;
        next_tick = 1'b0;
        if (enable_i) begin
            if (count == LAST) begin
                next_tick = 1'b1;
            end else begin
                next_count = CW'(count + 1'b1);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            count <= '0;
            tick_o <= 1'b0;
        end else begin
            count <= next_count;
            tick_o <= next_tick;
        end
    end

    // Ticks never come on two consecutive cycles
    a_tick_spacing: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        tick_o |=> !tick_o)
        else $error("sample ticks too close");
endmodule // sample_clock_div

// ===== hdl/result_latch.sv
// Holds the converter result, right-justified and extended to 16 bits
`timescale 1ns/100ps
module result_latch #(
    parameter int RESULT_W = 12,
    parameter bit BIPOLAR = 1'b1
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Converter side
    input wire logic capture_i,
    input wire logic [adc_ctrl_pkg::CONV_W-1:0] raw_i,
    // Formatted word
    output logic [adc_ctrl_pkg::ACC_W-1:0] word_o
);
    logic [adc_ctrl_pkg::ACC_W-1:0] next_word;
    logic sign_fill;

    // Low bits take the result, upper bits zero fill or sign copy
    always_comb begin
        sign_fill = BIPOLAR & raw_i[RESULT_W-1];
        next_word = word_o;
        if (capture_i) begin
            next_word = {{(adc_ctrl_pkg::ACC_W - RESULT_W){sign_fill}},
                raw_i[RESULT_W-1:0]};
        end
    end

    // Only a new conversion replaces the held word
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            word_o <= adc_ctrl_pkg::RESULT_RST;
        end else begin
            word_o <= next_word;
        end
    end

    a_result_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !capture_i |=> $stable(word_o))
        else $error("result changed without a conversion");
    a_result_fill: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        capture_i |=> word_o[RESULT_W-1:0] == $past(raw_i[RESULT_W-1:0])
        && (word_o[adc_ctrl_pkg::ACC_W-1]
        == (BIPOLAR & $past(raw_i[RESULT_W-1]))))
        else $error("result not justified or extended");
endmodule // result_latch

// ===== hdl/adc_single_conversion_controller.sv
// Converter controller: flags, channel pointer, gain, start and result path
// How it works
// - Channels are numbered from zero to installed count minus one.
// - Console reset clears busy and done; clear command and I/O reset clear busy, and done unless a single-mode end of conversion coincides.
// - Start sets busy, clears done, picks single mode, triggers conversion.
// - Pulse sets busy, clears done, picks data channel mode and sequence.
// - Eight-bit channel pointer, written and read back by the host.
// - Pointer increments at each end of conversion unless disabled or written by a channel write in that cycle.
// - Only the low five pointer bits drive the multiplexer.
// - Without a multiplexer the pointer is kept but has no effect.
// - With a sampling clock enabled, start arms; next tick converts.
// - Single mode end of conversion clears busy, sets done, requests irq.
// - Channel write takes accumulator bits 8-15, then applies function.
// - Channel read returns pointer in bits 8-15, zeros in bits 0-7.
// - Gain write takes bits 0-1; no-op without the gain option.
// - Gain code selects amplification; 00 is unity, 01 doubles.
// - Gain codes give factors one, two, four and eight.
// - Result read right-justifies result, zero fill or sign extension.
// - Result stays readable, unchanged, until next conversion ends.
`timescale 1ns/100ps
module adc_single_conversion_controller #(
    parameter bit MUX_FITTED = 1'b1,
    parameter bit GAIN_FITTED = 1'b1,
    parameter int RESULT_W = 12,
    parameter bit BIPOLAR = 1'b1,
    parameter int SAMPLE_PERIOD_CYC = adc_ctrl_pkg::SAMPLE_PERIOD_CYC
) (
    // Clock and console reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Programmed I/O transfers
    input wire logic io_strobe_i,
    input wire logic [2:0] io_op_i,
    input wire logic [1:0] io_func_i,
    input wire logic [15:0] io_data_i,
    input wire logic io_reset_i,
    output logic [15:0] io_rdata_o,
    output logic io_rvalid_o,
    // Flags and interrupt request
    output logic busy_o,
    output logic done_o,
    output logic irq_o,
    output logic dc_mode_o,
    // Controller adjustments and external sampling clock
    input wire logic int_clk_en_i,
    input wire logic ext_clk_en_i,
    input wire logic ext_sample_i,
    input wire logic auto_inc_dis_i,
    // Converter, multiplexer and amplifier
    output logic conv_start_o,
    input wire logic conv_eoc_i,
    input wire logic [11:0] conv_data_i,
    output logic [4:0] mux_channel_o,
    output logic [1:0] gain_code_o,
    output logic [3:0] gain_factor_o
);
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_armed = 3'b010,
        st_conv = 3'b100
    } conv_state_e;

    // Amplification factor of a gain code: 1, 2, 4 or 8
    function automatic logic [3:0] gain_factor(input logic [1:0] code);
        gain_factor = 4'h1 << code;
    endfunction

    conv_state_e state;
    conv_state_e next_state;
    logic [7:0] channel_pointer;
    logic [7:0] next_channel_pointer;
    logic [1:0] amplification_setting;
    logic [1:0] next_amplification_setting;
    logic [15:0] conversion_result;
    logic next_busy;
    logic next_done;
    logic next_dc_mode;
    logic next_conv_start;
    logic [15:0] next_rdata;
    logic next_rvalid;
    logic [4:0] next_mux;
    logic int_tick;
    logic clock_active;
    logic tick;
    logic start_cmd;
    logic pulse_cmd;
    logic clear_cmd;
    logic eoc_ev;
    logic chan_wr;
    logic chan_rd;
    logic gain_wr;
    logic result_rd;

    // Internal sampling clock
    sample_clock_div #(
        .PERIOD_CYC(SAMPLE_PERIOD_CYC)
    ) u_div (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .enable_i(int_clk_en_i),
        .tick_o(int_tick)
    );

    // Converter result holding register
    result_latch #(
        .RESULT_W(RESULT_W),
        .BIPOLAR(BIPOLAR)
    ) u_result (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .capture_i(eoc_ev),
        .raw_i(conv_data_i),
        .word_o(conversion_result)
    );

    // Decode of the transfer and its function field
    always_comb begin
        chan_wr = io_strobe_i && io_op_i == adc_ctrl_pkg::OP_CHAN_WR;
        chan_rd = io_strobe_i && io_op_i == adc_ctrl_pkg::OP_CHAN_RD;
        gain_wr = io_strobe_i && io_op_i == adc_ctrl_pkg::OP_GAIN_WR;
        result_rd = io_strobe_i && io_op_i == adc_ctrl_pkg::OP_RESULT_RD;
        start_cmd = io_strobe_i && io_func_i == adc_ctrl_pkg::FN_START;
        pulse_cmd = io_strobe_i && io_func_i == adc_ctrl_pkg::FN_PULSE;
        clear_cmd = (io_strobe_i && io_func_i == adc_ctrl_pkg::FN_CLEAR)
            || io_reset_i;
        clock_active = int_clk_en_i || ext_clk_en_i;
        tick = (int_clk_en_i && int_tick) || (ext_clk_en_i && ext_sample_i);
        eoc_ev = conv_eoc_i && state == st_conv;
    end

    // Flags, sequencing and conversion trigger
    always_comb begin
        next_state = state;
        next_busy = busy_o;
        next_done = done_o;
        next_dc_mode = dc_mode_o;
        next_conv_start = 1'b0;
        case (state)
            st_idle: begin
                next_state = st_idle;
            end
            st_armed: begin
                if (tick) begin
                    next_state = st_conv;
                    next_conv_start = 1'b1;
                end
            end
            st_conv: begin
                if (eoc_ev && dc_mode_o) begin
                    next_state = clock_active ? st_armed : st_conv;
                    next_conv_start = !clock_active;
                end else if (eoc_ev) begin
                    next_state = st_idle;
                    next_busy = 1'b0;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
        if (clear_cmd) begin
            next_busy = 1'b0;
            next_done = 1'b0;
            next_state = st_idle;
            next_conv_start = 1'b0;
        end
        if ((start_cmd || pulse_cmd) && !io_reset_i) begin
            next_busy = 1'b1;
            next_done = 1'b0;
            next_dc_mode = pulse_cmd;
            next_state = clock_active ? st_armed : st_conv;
            next_conv_start = !clock_active;
        end
        if (eoc_ev && !dc_mode_o) begin
            next_done = 1'b1;
        end
    end

    // Channel pointer and gain setting
    always_comb begin
        next_channel_pointer = channel_pointer;
        next_amplification_setting = amplification_setting;
        if (chan_wr) begin
            next_channel_pointer = io_data_i[adc_ctrl_pkg::ACC_CHAN_LSB +:
                adc_ctrl_pkg::CHAN_W];
        end else if (eoc_ev && !auto_inc_dis_i) begin
            next_channel_pointer = 8'(channel_pointer + 8'h01);
        end
        if (gain_wr && GAIN_FITTED) begin
            next_amplification_setting = io_data_i[adc_ctrl_pkg::ACC_GAIN_LSB +:
                adc_ctrl_pkg::GAIN_W];
        end
        next_mux = MUX_FITTED ? channel_pointer[4:0] : 5'h00;
    end

    // Read data returned to the accumulator
    always_comb begin
        next_rdata = io_rdata_o;
        next_rvalid = chan_rd || result_rd;
        if (chan_rd) begin
            next_rdata = {8'h00, channel_pointer};
        end else if (result_rd) begin
            next_rdata = conversion_result;
        end
    end

    // State registers and registered outputs
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state <= st_idle;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            irq_o <= 1'b0;
            dc_mode_o <= 1'b0;
            conv_start_o <= 1'b0;
            channel_pointer <= adc_ctrl_pkg::CHAN_RST;
            amplification_setting <= adc_ctrl_pkg::GAIN_RST;
            mux_channel_o <= 5'h00;
            gain_code_o <= adc_ctrl_pkg::GAIN_RST;
            gain_factor_o <= 4'h1;
            io_rdata_o <= 16'h0000;
            io_rvalid_o <= 1'b0;
        end else begin
            state <= next_state;
            busy_o <= next_busy;
            done_o <= next_done;
            irq_o <= next_done;
            dc_mode_o <= next_dc_mode;
            conv_start_o <= next_conv_start;
            channel_pointer <= next_channel_pointer;
            amplification_setting <= next_amplification_setting;
            mux_channel_o <= next_mux;
            gain_code_o <= next_amplification_setting;
            gain_factor_o <= gain_factor(next_amplification_setting);
            io_rdata_o <= next_rdata;
            io_rvalid_o <= next_rvalid;
        end
    end

    a_start_sets_busy: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        start_cmd && !io_reset_i && !eoc_ev |=> busy_o && !done_o
        && !dc_mode_o)
        else $error("start did not set busy and clear done");
    a_eoc_sets_done: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        eoc_ev && !dc_mode_o && !start_cmd && !pulse_cmd
        |=> done_o && irq_o && !busy_o)
        else $error("end of conversion did not set done");
    a_clear_flags: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        clear_cmd && !eoc_ev && !(start_cmd && !io_reset_i) && !pulse_cmd
        |=> !busy_o && !done_o)
        else $error("clear left a flag set");
    a_chan_write: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        chan_wr |=> channel_pointer == $past(io_data_i[7:0]))
        else $error("channel write not loaded");
    a_chan_incr: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        eoc_ev && !auto_inc_dis_i && !chan_wr
        |=> channel_pointer == 8'($past(channel_pointer) + 8'h01))
        else $error("channel pointer did not increment");
    a_chan_read: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        chan_rd |=> io_rvalid_o && io_rdata_o[15:8] == 8'h00
        && io_rdata_o[7:0] == $past(channel_pointer))
        else $error("channel read value wrong");
    a_direct_start: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        start_cmd && !io_reset_i && !clock_active |=> conv_start_o)
        else $error("start did not trigger at once");
    a_armed_waits: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        state == st_armed && !tick |=> !conv_start_o)
        else $error("conversion began before a tick");
    a_mux_low_bits: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        1'b1 |=> mux_channel_o == (MUX_FITTED ?
        $past(channel_pointer[4:0]) : 5'h00))
        else $error("multiplexer select wrong");
    a_gain_factor: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        gain_factor_o == (gain_code_o == 2'h0 ? 4'h1
        : gain_code_o == 2'h1 ? 4'h2
        : gain_code_o == 2'h2 ? 4'h4 : 4'h8))
        else $error("gain factor does not match code");
    a_pulse_sets_mode: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        pulse_cmd && !io_reset_i && !eoc_ev
        |=> busy_o && !done_o && dc_mode_o)
        else $error("pulse did not select data channel mode");
    a_gain_write: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        gain_wr |=> gain_code_o == (GAIN_FITTED ?
        $past(io_data_i[15:14]) : $past(gain_code_o)))
        else $error("gain write not handled");
    a_result_read: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        result_rd |=> io_rvalid_o
        && io_rdata_o == $past(conversion_result))
        else $error("result read value wrong");
endmodule // adc_single_conversion_controller

// ===== verification/conv_model.sv
// Behavioural converter answering start pulses with a delayed result
`timescale 1ns/100ps
module conv_model #(
    parameter int DELAY = 4
) (
    // Clock
    input wire logic mclk_i,
    // Controller side
    input wire logic start_i,
    input wire logic [11:0] level_i,
    output logic eoc_o,
    output logic [11:0] data_o
);
    int cnt = 0;
    // Count down from each start, end of conversion on the last cycle
    always @(posedge mclk_i) begin
        if (start_i) begin
            cnt <= DELAY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign eoc_o = (cnt == 1);
    // Data lines are only meaningful in the end of conversion cycle
    assign data_o = eoc_o ? level_i : ~level_i;
endmodule // conv_model

// ===== verification/tb_top.sv
// Self-checking bench for the single-conversion controller
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [2:0] op;
        logic [15:0] d;
        logic [15:0] e;
    } row_s;
    logic mclk = 1'b0;
    logic rst_n, strobe, io_rst, rvalid, busy, done, irq, dc;
    logic int_en, ext_en, ext_smp, inc_dis, cstart, eoc, got_rv;
    logic [2:0] op;
    logic [1:0] func, gcode;
    logic [15:0] wdata, rdata, got_rd;
    logic [11:0] cdata, level;
    logic [4:0] mux;
    logic [3:0] gfac;
    int bad_count = 0;
    int compares = 0;
    row_s rows[7] = '{
        {adc_ctrl_pkg::OP_CHAN_WR, 16'hff05, 16'h0005},
        {adc_ctrl_pkg::OP_CHAN_WR, 16'h00ff, 16'h00ff},
        {adc_ctrl_pkg::OP_CHAN_WR, 16'h1200, 16'h0000},
        {adc_ctrl_pkg::OP_GAIN_WR, 16'h3fff, 16'h0001},
        {adc_ctrl_pkg::OP_GAIN_WR, 16'h4000, 16'h0012},
        {adc_ctrl_pkg::OP_GAIN_WR, 16'h8000, 16'h0024},
        {adc_ctrl_pkg::OP_GAIN_WR, 16'hc000, 16'h0038}
    };
    // Clock
    always #5 mclk = ~mclk;
    adc_single_conversion_controller #(
        .SAMPLE_PERIOD_CYC(8)
    ) DUT (
        .mclk_i(mclk), .reset_n_i(rst_n), .io_strobe_i(strobe),
        .io_op_i(op), .io_func_i(func), .io_data_i(wdata),
        .io_reset_i(io_rst), .io_rdata_o(rdata), .io_rvalid_o(rvalid),
        .busy_o(busy), .done_o(done), .irq_o(irq), .dc_mode_o(dc),
        .int_clk_en_i(int_en), .ext_clk_en_i(ext_en),
        .ext_sample_i(ext_smp), .auto_inc_dis_i(inc_dis),
        .conv_start_o(cstart), .conv_eoc_i(eoc), .conv_data_i(cdata),
        .mux_channel_o(mux), .gain_code_o(gcode), .gain_factor_o(gfac)
    );
    conv_model #(
        .DELAY(4)
    ) conv (
        .mclk_i(mclk), .start_i(cstart), .level_i(level),
        .eoc_o(eoc), .data_o(cdata)
    );
    // Report counts and verdict, then stop
    task end_sim;
        $display("Compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // One strobed transfer, answer captured, then one idle cycle
    task xfer(input logic [2:0] o, input logic [1:0] f,
              input logic [15:0] d);
        strobe = 1'b1;
        op = o;
        func = f;
        wdata = d;
        @(negedge mclk);
        got_rv = rvalid;
        got_rd = rdata;
        strobe = 1'b0;
        @(negedge mclk);
    endtask
    task rd(input logic [2:0] o, input logic [1:0] f,
            input logic [15:0] exp);
        xfer(o, f, 16'h0000);
        chk({15'h0, got_rv}, 16'h0001);
        chk(got_rd, exp);
    endtask
    // Bounded wait for done, a timeout ends the run
    task wait_done;
        for (int i = 0; i < 200 && done !== 1'b1; i++) begin
            @(negedge mclk);
        end
        if (done !== 1'b1) begin
            $display("[ERR] %0t got %h exp %h", $time, done, 1'b1);
            bad_count++;
            end_sim();
        end
    endtask
    // Main sequence
    initial begin
        {rst_n, strobe, io_rst, int_en, ext_en, ext_smp, inc_dis} = '0;
        op = adc_ctrl_pkg::OP_NONE;
        func = adc_ctrl_pkg::FN_NONE;
        wdata = 16'h0000;
        level = 12'h9ab;
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        chk({12'h0, busy, done, irq, dc}, 16'h0000);
        chk({12'h0, gfac}, 16'h0001);
        // Throwaway conversion with a bare start
        xfer(adc_ctrl_pkg::OP_NONE, adc_ctrl_pkg::FN_START, 0);
        chk({14'h0, busy, done}, 16'h0002);
        wait_done();
        chk({13'h0, busy, done, irq}, 16'h0003);
        rd(adc_ctrl_pkg::OP_CHAN_RD, adc_ctrl_pkg::FN_NONE, 1);
        // Table of register writes, checked by channel read or gain outputs
        for (int i = 0; i < 7; i++) begin
            xfer(rows[i].op, adc_ctrl_pkg::FN_NONE, rows[i].d);
            if (rows[i].op == adc_ctrl_pkg::OP_CHAN_WR) begin
                rd(adc_ctrl_pkg::OP_CHAN_RD, 0, rows[i].e);
            end else begin
                chk({10'h0, gcode, gfac}, rows[i].e);
            end
        end
        // Channel write with start, upper pointer bits kept
        xfer(adc_ctrl_pkg::OP_CHAN_WR, 1, 16'h00e3);
        cyc(1);
        chk({11'h0, mux}, 16'h0003);
        wait_done();
        rd(adc_ctrl_pkg::OP_CHAN_RD, 0, 16'h00e4);
        rd(adc_ctrl_pkg::OP_RESULT_RD, 2, 16'hf9ab);
        chk({15'h0, done}, 16'h0000);
        level = 12'h123;
        rd(adc_ctrl_pkg::OP_RESULT_RD, 1, 16'hf9ab);
        chk({15'h0, busy}, 16'h0001);
        wait_done();
        rd(adc_ctrl_pkg::OP_RESULT_RD, 0, 16'h0123);
        // Increment disabled keeps the pointer
        inc_dis = 1'b1;
        xfer(adc_ctrl_pkg::OP_NONE, adc_ctrl_pkg::FN_START, 0);
        wait_done();
        rd(adc_ctrl_pkg::OP_CHAN_RD, 0, 16'h00e5);
        inc_dis = 1'b0;
        // I/O reset in mid-conversion
        xfer(adc_ctrl_pkg::OP_NONE, adc_ctrl_pkg::FN_START, 0);
        io_rst = 1'b1;
        cyc(1);
        io_rst = 1'b0;
        chk({14'h0, busy, done}, 16'h0000);
        cyc(8);
        // Pulse runs a sequence without setting done
        xfer(adc_ctrl_pkg::OP_NONE, adc_ctrl_pkg::FN_PULSE, 0);
        chk({14'h0, busy, dc}, 16'h0003);
        cyc(20);
        chk({14'h0, busy, done}, 16'h0002);
        xfer(adc_ctrl_pkg::OP_NONE, adc_ctrl_pkg::FN_CLEAR, 0);
        chk({14'h0, busy, done}, 16'h0000);
        cyc(8);
        // External sampling clock arms the start until a pulse
        ext_en = 1'b1;
        xfer(adc_ctrl_pkg::OP_NONE, adc_ctrl_pkg::FN_START, 0);
        cyc(20);
        chk({13'h0, busy, done, cstart}, 16'h0004);
        ext_smp = 1'b1;
        cyc(1);
        chk({15'h0, cstart}, 16'h0001);
        ext_smp = 1'b0;
        wait_done();
        ext_en = 1'b0;
        // Internal sampling clock triggers a conversion that sets done within the bounded wait
        int_en = 1'b1;
        xfer(adc_ctrl_pkg::OP_NONE, adc_ctrl_pkg::FN_START, 0);
        wait_done();
        chk({13'h0, busy, done, irq}, 16'h0003);
        end_sim();
    end
endmodule // tb_top
